// ### hdl/wake_packet_filter_tables.sv
// wake-up filter tables and received-byte match logic
`timescale 1ns/100ps
// Operation
// R1 - enable register bits 0..7 enable filters 8..15; reset zero; 15:8 read zero
// R2 - status register bits 0..7 flag filters 8..15 matched; reset zero
// R3 - four IPv6 addresses, sixteen bytes each, byte 0 first on wire
// R4 - directed IPv6 wake compares only address 0; proxy may read any
// R5 - multicast hash table is 32 words of 32 bits
// R6 - software uses whole 32-bit words on the hash table
// R7 - offset 00 indexes with address bits 47:38, offset 01 with 46:37
// R8 - offset 10 indexes with address bits 45:36, offset 11 with 43:34
// R9 - stored destination address bit 0 of byte 0 is first on wire
// R10 - 128 value entries; even filter in bits 7:0, odd in 15:8
// R11 - 128 mask entries from register 768; bit k masks filter k
// R12 - mask bit set means compare the byte; clear means ignore it
// R13 - software disables filters before writing value or mask entries
// R14 - filters 0/1 at 256+2n, filters 2/3 at 257+2n
// R15 - filters 4/5 at 512+2n, filters 6/7 at 1024+2n
// R16 - pass on reaching minimum length without mismatch; shorter never passes
// R17 - upper five index bits pick the word, lower five the bit
// R18 - enabled passing filter sets its status bit until software clears it
module wake_packet_filter_tables import wake_filter_pkg::*; (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [REG_AW-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    input wire logic [NUM_FLEX-1:0] flex_enable_lo,
    input wire logic [NUM_FLEX-1:0][LEN_W-1:0] min_len,
    input wire logic [1:0] mc_offset,
    input wire logic [NUM_FLEX-1:0] hi_filter_pass,
    output logic [NUM_FLEX-1:0] filter_enable_hi,
    output logic [NUM_FLEX-1:0] flex_match_lo,
    output logic mc_hit,
    output logic ipv6_directed_hit,
    input wire logic [1:0] proxy_sel,
    output logic [127:0] proxy_addr
);
    // =================================================================
    // storage
    logic [7:0] enable_hi_q;
    logic [7:0] match_q;
    logic [15:0] ip6_q [IPV6_HALVES];
    logic [31:0] mta_q [MTA_WORDS];
    logic [15:0] val01_q [FLEX_DEPTH];
    logic [15:0] val23_q [FLEX_DEPTH];
    logic [15:0] val45_q [FLEX_DEPTH];
    logic [15:0] val67_q [FLEX_DEPTH];
    logic [7:0] mask_q [FLEX_DEPTH];
    logic [15:0] reg_rdata_q;
    logic reg_rvalid_q;

    // =================================================================
    // register decode
    wire hit_en = (reg_addr == ENABLE_HI_REG);
    wire hit_mt = (reg_addr == MATCH_HI_REG);
    wire hit_ip = in_range(reg_addr, IPV6_BASE, IPV6_REGS);
    wire hit_mta = in_range(reg_addr, MTA_BASE, MTA_REGS);
    wire hit_v01 = in_range(reg_addr, VAL01_BASE, VAL_REGS) && !reg_addr[0]; // R14
    wire hit_v23 = in_range(reg_addr, VAL23_BASE, VAL_REGS) && reg_addr[0]; // R14
    wire hit_v45 = in_range(reg_addr, VAL45_BASE, VAL_REGS) && !reg_addr[0]; // R15
    wire hit_v67 = in_range(reg_addr, VAL67_BASE, VAL_REGS) && !reg_addr[0]; // R15
    wire hit_msk = in_range(reg_addr, MASK_BASE, MASK_REGS); // R11
    wire [11:0] ip_diff = reg_addr - IPV6_BASE;
    wire [11:0] mta_diff = reg_addr - MTA_BASE;
    wire [11:0] val23_diff = reg_addr - VAL23_BASE;
    wire [4:0] ip_off = ip_diff[4:0];
    wire [4:0] mta_word = mta_diff[5:1];
    wire mta_upper = mta_diff[0];
    // value entry n sits at base + 2n, so the index is the address over two
    wire [6:0] val_idx = hit_v23 ? val23_diff[7:1] : reg_addr[7:1]; // R10
    wire [6:0] msk_idx = reg_addr[6:0];
    wire [15:0] mta_half = mta_upper ? mta_q[mta_word][31:16] : mta_q[mta_word][15:0];

    wire [15:0] rd_mux =
        hit_en ? {8'h00, enable_hi_q} : // R1
        hit_mt ? {8'h00, match_q} :
        hit_ip ? ip6_q[ip_off] :
        hit_mta ? mta_half :
        hit_v01 ? val01_q[val_idx] :
        hit_v23 ? val23_q[val_idx] :
        hit_v45 ? val45_q[val_idx] :
        hit_v67 ? val67_q[val_idx] :
        hit_msk ? {8'h00, mask_q[msk_idx]} : // R11
        16'h0000;

    // =================================================================
    // receive path
    rx_beat_t in_beat;
    rx_beat_t beat;
    logic beat_valid;
    logic beat_ready;

    assign in_beat = '{last: rx_last, data: rx_data};
    // tables may change under a write, so the compare pauses for it
    assign beat_ready = !reg_wr; // R13

    rx_pair_buffer #(
        .WIDTH($bits(rx_beat_t)),
        .DEPTH(2)
    ) u_rx_buf (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .in_valid(rx_valid),
        .in_ready(rx_ready),
        .in_data(in_beat),
        .out_valid(beat_valid),
        .out_ready(beat_ready),
        .out_data(beat)
    );

    // =================================================================
    // flexible filter compare
    pkt_state_t st_q;
    pkt_state_t st_d;
    logic [10:0] idx_q;
    logic [NUM_FLEX-1:0] mism_q;
    logic [NUM_FLEX-1:0] flex_match_q;
    logic [47:0] da_q;
    logic da_ready_q;
    logic mc_hit_q;
    logic ip_ok_q;
    logic ip_hit_q;
    logic [127:0] proxy_q;
    logic [127:0] proxy_w;

    wire take = beat_valid && beat_ready;
    wire [6:0] tix = idx_q[6:0];
    wire in_table = (st_q != ST_TAIL);
    // byte f of this word belongs to filter f
    wire [63:0] vals = {val67_q[tix], val45_q[tix], val23_q[tix], val01_q[tix]}; // R10
    wire [7:0] cur_mask = mask_q[tix];
    wire [10:0] idx_next = idx_q + 11'h001;
    logic [NUM_FLEX-1:0] cmp_fail;
    logic [NUM_FLEX-1:0] reach;

    always_comb
    begin
        for (int f = 0; f < NUM_FLEX; f++)
        begin
            cmp_fail[f] = in_table && cur_mask[f] && (vals[8*f +: 8] != beat.data); // R12
            reach[f] = (idx_next == min_len[f]); // R16
        end
    end

    wire [NUM_FLEX-1:0] bad_now = mism_q | cmp_fail;
    // no bytes past the length are looked at: pass fires only at it
    wire [NUM_FLEX-1:0] pass_now = take ? (flex_enable_lo & reach & ~bad_now) : '0; // R16

    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            ST_DA: if (idx_q == DA_LAST) st_d = ST_BODY;
            ST_BODY: if (idx_q == TABLE_LAST) st_d = ST_TAIL;
            ST_TAIL: st_d = ST_TAIL;
            default: st_d = ST_DA;
        endcase
        if (beat.last)
            st_d = ST_DA;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_q <= ST_DA;
            idx_q <= '0;
            mism_q <= '0;
            flex_match_q <= '0;
        end
        else
        begin
            flex_match_q <= pass_now;
            if (take)
            begin
                st_q <= st_d;
                idx_q <= beat.last ? '0 : ((idx_q == IDX_MAX) ? idx_q : idx_next);
                mism_q <= beat.last ? '0 : bad_now; // R12
            end
        end
    end

    // =================================================================
    // multicast hash lookup
    wire [9:0] mc_ix = mc_index(da_q, mc_offset_t'(mc_offset)); // R7 R8
    wire mta_bit = mta_q[mc_ix[9:5]][mc_ix[4:0]]; // R17 R5

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            da_q <= '0;
            da_ready_q <= 1'b0;
            mc_hit_q <= 1'b0;
        end
        else
        begin
            // first wire byte lands in da_q[7:0], its first bit in bit 0
            if (take && st_q == ST_DA)
                da_q[8*idx_q[2:0] +: 8] <= beat.data; // R9
            da_ready_q <= take && (st_q == ST_DA) && (idx_q == DA_LAST);
            mc_hit_q <= da_ready_q && da_q[0] && mta_bit; // R17
        end
    end

    // =================================================================
    // directed IPv6 wake, address 0 only
    wire in_ip_win = (st_q == ST_BODY) && (idx_q >= IPV6_DST_FIRST) && (idx_q <= IPV6_DST_LAST);
    wire [10:0] ip_rel = idx_q - IPV6_DST_FIRST;
    wire [15:0] ip_half = ip6_q[{2'b00, ip_rel[3:1]}]; // R4
    wire [7:0] ip_byte = ip_rel[0] ? ip_half[15:8] : ip_half[7:0]; // R3
    wire ip_eq = (ip_byte == beat.data);
    wire ip_ok_now = ((idx_q == IPV6_DST_FIRST) || ip_ok_q) && ip_eq;

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ip_ok_q <= 1'b0;
            ip_hit_q <= 1'b0;
        end
        else
        begin
            if (take && in_ip_win)
                ip_ok_q <= ip_ok_now;
            ip_hit_q <= take && in_ip_win && (idx_q == IPV6_DST_LAST) && ip_ok_now; // R4
        end
    end

    // proxy side may fetch any of the four addresses
    always_comb
    begin
        for (int k = 0; k < 8; k++)
        begin
            proxy_w[16*k +: 16] = ip6_q[{proxy_sel, 3'(k)}]; // R4 R3
        end
    end

    // =================================================================
    // control registers
    wire wr_en = reg_wr && hit_en;
    wire wr_mt = reg_wr && hit_mt;
    wire [7:0] hi_set = hi_filter_pass & enable_hi_q;
    // a pass in the same cycle as a software clear still lands
    wire [7:0] match_d = (wr_mt ? reg_wdata[7:0] : match_q) | hi_set; // R18 R2

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            enable_hi_q <= ENABLE_HI_RST;
            match_q <= MATCH_HI_RST;
            reg_rdata_q <= 16'h0000;
            reg_rvalid_q <= 1'b0;
            proxy_q <= '0;
        end
        else
        begin
            if (wr_en)
                enable_hi_q <= reg_wdata[7:0]; // R1
            match_q <= match_d; // R2
            reg_rvalid_q <= reg_rd;
            if (reg_rd)
                reg_rdata_q <= rd_mux;
            proxy_q <= proxy_w;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            for (int i = 0; i < IPV6_HALVES; i++) ip6_q[i] <= IPV6_RST;
        else if (reg_wr && hit_ip)
            ip6_q[ip_off] <= reg_wdata; // R3
    end

    // =================================================================
    // tables without reset
    always_ff @(posedge ref_clk)
    begin
        if (reg_wr && hit_mta && mta_upper)
            mta_q[mta_word][31:16] <= reg_wdata; // R5
        if (reg_wr && hit_mta && !mta_upper)
            mta_q[mta_word][15:0] <= reg_wdata; // R5
        if (reg_wr && hit_v01)
            val01_q[val_idx] <= reg_wdata; // R14
        if (reg_wr && hit_v23)
            val23_q[val_idx] <= reg_wdata; // R14
        if (reg_wr && hit_v45)
            val45_q[val_idx] <= reg_wdata; // R15
        if (reg_wr && hit_v67)
            val67_q[val_idx] <= reg_wdata; // R15
        if (reg_wr && hit_msk)
            mask_q[msk_idx] <= reg_wdata[7:0]; // R11
    end

    assign filter_enable_hi = enable_hi_q;
    assign flex_match_lo = flex_match_q;
    assign mc_hit = mc_hit_q;
    assign ipv6_directed_hit = ip_hit_q;
    assign proxy_addr = proxy_q;
    assign reg_rdata = reg_rdata_q;
    assign reg_rvalid = reg_rvalid_q;

    // =================================================================
    // assertions
    sequence seq_da_done;
        take && (st_q == ST_DA) && (idx_q == DA_LAST) ##1 da_ready_q;
    endsequence

    sequence seq_en_write;
        reg_wr && hit_en;
    endsequence

    AST_EN_HI_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst) // R1
        seq_en_write |=> filter_enable_hi == $past(reg_wdata[7:0]))
        else $error("enable register did not take the written value");

    AST_RSVD_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst) // R1
        reg_rd && (hit_en || hit_mt || hit_msk) |=> reg_rvalid && reg_rdata[15:8] == 8'h00)
        else $error("reserved high byte read nonzero");

    AST_MATCH_SET: assert property (@(posedge ref_clk) disable iff (sys_rst) // R18
        (hi_filter_pass & filter_enable_hi) != 8'h00
        |=> (match_q & $past(hi_filter_pass & filter_enable_hi))
            == $past(hi_filter_pass & filter_enable_hi))
        else $error("enabled filter pass did not set its status bit");

    AST_MATCH_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst) // R2
        !(reg_wr && hit_mt) ##1 !(reg_wr && hit_mt) |-> match_q == ($past(match_q) | $past(hi_set)))
        else $error("status bits changed without cause");

    AST_MC_LOOKUP: assert property (@(posedge ref_clk) disable iff (sys_rst) // R17
        seq_da_done |=> mc_hit == ($past(da_q[0]) && $past(mta_bit)))
        else $error("multicast lookup result wrong");

    AST_FLEX_AT_LEN: assert property (@(posedge ref_clk) disable iff (sys_rst) // R16
        flex_match_lo != 8'h00 |-> $past(take) && (($past(reach) & flex_match_lo) == flex_match_lo))
        else $error("flexible pass away from minimum length");

    AST_MISMATCH_BLOCKS: assert property (@(posedge ref_clk) disable iff (sys_rst) // R12
        take && !beat.last && cmp_fail != 8'h00
        |=> (mism_q & $past(cmp_fail)) == $past(cmp_fail) && (pass_now & $past(cmp_fail)) == 8'h00)
        else $error("masked mismatch not held against the packet");

    AST_IPV6_HIT: assert property (@(posedge ref_clk) disable iff (sys_rst) // R4
        ipv6_directed_hit |-> $past(take) && $past(idx_q) == IPV6_DST_LAST && $past(ip_eq))
        else $error("directed address hit at wrong byte");

    AST_WRITE_STALL: assert property (@(posedge ref_clk) disable iff (sys_rst) // R13
        reg_wr |-> !take)
        else $error("byte compared during a table write");
endmodule : wake_packet_filter_tables

// ### hdl/wake_filter_pkg.sv
// constants and types shared by the wake packet filter tables
package wake_filter_pkg;
    // =================================================================
    // sizes
    localparam int NUM_FLEX = 8;
    localparam int FLEX_DEPTH = 128;
    localparam int LEN_W = 11;
    localparam int REG_AW = 12;
    localparam int IPV6_HALVES = 32;
    localparam int MTA_WORDS = 32;
    // =================================================================
    // register numbers and extents
    localparam logic [11:0] ENABLE_HI_REG = 12'h04c;
    localparam logic [11:0] MATCH_HI_REG = 12'h04d;
    localparam logic [11:0] IPV6_BASE = 12'h058;
    localparam logic [12:0] IPV6_REGS = 13'h0020;
    localparam logic [11:0] MTA_BASE = 12'h080;
    localparam logic [12:0] MTA_REGS = 13'h0040;
    localparam logic [11:0] VAL01_BASE = 12'h100;
    localparam logic [11:0] VAL23_BASE = 12'h101;
    localparam logic [11:0] VAL45_BASE = 12'h200;
    localparam logic [11:0] VAL67_BASE = 12'h400;
    localparam logic [12:0] VAL_REGS = 13'h0100;
    localparam logic [11:0] MASK_BASE = 12'h300;
    localparam logic [12:0] MASK_REGS = 13'h0080;
    // =================================================================
    // reset values
    localparam logic [7:0] ENABLE_HI_RST = 8'h00;
    localparam logic [7:0] MATCH_HI_RST = 8'h00;
    localparam logic [15:0] IPV6_RST = 16'h0000;
    // =================================================================
    // packet byte positions
    localparam logic [10:0] DA_LAST = 11'h005;
    localparam logic [10:0] IPV6_DST_FIRST = 11'h026;
    localparam logic [10:0] IPV6_DST_LAST = 11'h035;
    localparam logic [10:0] TABLE_LAST = 11'h07f;
    localparam logic [10:0] IDX_MAX = 11'h7ff;
    // =================================================================
    // types
    typedef struct packed {
        logic last;
        logic [7:0] data;
    } rx_beat_t;

    typedef enum logic [1:0] {
        ST_DA = 2'b00,
        ST_BODY = 2'b01,
        ST_TAIL = 2'b11
    } pkt_state_t;

    typedef enum logic [1:0] {
        MC_OFS_47 = 2'b00,
        MC_OFS_46 = 2'b01,
        MC_OFS_45 = 2'b10,
        MC_OFS_43 = 2'b11
    } mc_offset_t;
    // =================================================================
    // functions
    function automatic logic in_range(input logic [11:0] a,
                                      input logic [11:0] base,
                                      input logic [12:0] cnt);
        return (a >= base) && ({1'b0, a} < ({1'b0, base} + cnt));
    endfunction : in_range

    function automatic logic [9:0] mc_index(input logic [47:0] da,
                                            input mc_offset_t ofs);
        logic [9:0] r;
        unique case (ofs)
            MC_OFS_47: r = da[47:38];
            MC_OFS_46: r = da[46:37];
            MC_OFS_45: r = da[45:36];
            MC_OFS_43: r = da[43:34];
        endcase
        return r;
    endfunction : mc_index
endpackage : wake_filter_pkg

// ### hdl/rx_pair_buffer.sv
// small first-in first-out buffer for received bytes
`timescale 1ns/100ps
module rx_pair_buffer #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 2
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] store_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [CW-1:0] cnt_q;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : bump

    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    // full stalls the source, so a drained-side stall loses no byte
    assign in_ready = (cnt_q != CW'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = store_q[rd_q];

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= bump(wr_q);
            if (pop)
                rd_q <= bump(rd_q);
            cnt_q <= cnt_q + CW'(push) - CW'(pop);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (push)
            store_q[wr_q] <= in_data;
    end
endmodule : rx_pair_buffer

// ### test/rx_byte_source.sv
// byte stream source standing in for the receive line side
`timescale 1ns/100ps
module rx_byte_source (
    input wire logic ref_clk,
    input wire logic rx_ready,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last
);
    int hung = 0;
    initial
    begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_last = 1'b0;
    end
    // idle data shows the inverse of the last byte, so a stale sample is caught
    task automatic send(input logic [7:0] p [64], input int n, input bit slow);
        int w;
        @(posedge ref_clk);
        for (int i = 0; i < n; i++)
        begin
            rx_valid <= 1'b1;
            rx_data <= p[i];
            rx_last <= (i == n - 1);
            w = 0;
            do
                @(posedge ref_clk);
            while (!rx_ready && ++w < 60);
            hung += (w >= 60);
            if (slow || i == n - 1)
            begin
                rx_valid <= 1'b0;
                rx_data <= ~p[i];
                rx_last <= 1'b0;
            end
            if (slow)
                @(posedge ref_clk);
        end
    endtask : send
endmodule : rx_byte_source

// ### test/wake_packet_filter_tables_tb_top.sv
// self-checking bench for the wake packet filter tables
`timescale 1ns/100ps
module wake_packet_filter_tables_tb_top import wake_filter_pkg::*; ;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [REG_AW-1:0] reg_addr = 12'h000;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic reg_rvalid, rx_valid, rx_ready, rx_last, mc_hit, ipv6_directed_hit;
    logic [7:0] rx_data, filter_enable_hi, flex_match_lo, e, p;
    logic [7:0] flex_enable_lo = 8'h00;
    logic [7:0] hi_filter_pass = 8'h00;
    logic [NUM_FLEX-1:0][LEN_W-1:0] min_len = '0;
    logic [1:0] mc_offset = 2'h0;
    logic [1:0] proxy_sel = 2'h0;
    logic [127:0] proxy_addr, ex;
    logic [127:0] ipa = 128'hfe80_0000_0000_0000_0200_01ff_fe30_0100;
    logic [9:0] ix;
    logic [7:0] pk [64];
    logic [7:0] val [8][16];
    logic [7:0] msk [16];
    logic [7:0] ip6 [2][16];
    int minl [8];
    int fc [8];
    int vb [4] = '{256, 257, 512, 1024};
    int failures = 0, compares = 0, mc_cnt = 0, ip_cnt = 0, full_seen = 0, hb = 128, m;
    bit hash [1024];

    wake_packet_filter_tables wake_packet_filter_tables_inst (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_last(rx_last),
        .flex_enable_lo(flex_enable_lo), .min_len(min_len), .mc_offset(mc_offset),
        .hi_filter_pass(hi_filter_pass), .filter_enable_hi(filter_enable_hi),
        .flex_match_lo(flex_match_lo), .mc_hit(mc_hit),
        .ipv6_directed_hit(ipv6_directed_hit), .proxy_sel(proxy_sel),
        .proxy_addr(proxy_addr));
    rx_byte_source rx_byte_source_inst (.ref_clk(ref_clk), .rx_ready(rx_ready),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last));

    initial
        forever #10 ref_clk = ~ref_clk;
    // pulses are counted, not timed, so a late or doubled pulse still shows up
    always @(posedge ref_clk)
    begin
        foreach (fc[f])
            fc[f] += (flex_match_lo[f] === 1'b1);
        mc_cnt += (mc_hit === 1'b1);
        ip_cnt += (ipv6_directed_hit === 1'b1);
        full_seen += (rx_valid === 1'b1 && rx_ready === 1'b0);
    end
    // ========
    // tasks
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out
    task automatic wr(input int a, input logic [15:0] d, input int n = 1);
        @(posedge ref_clk);
        reg_addr <= a[11:0];
        reg_wdata <= d;
        reg_wr <= 1'b1;
        repeat (n) @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr
    task automatic rchk(input int a, input logic [15:0] x);
        int w;
        @(posedge ref_clk);
        reg_addr <= a[11:0];
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        w = 0;
        do
            @(negedge ref_clk);
        while (reg_rvalid !== 1'b1 && ++w < 4);
        if (w >= 4)
        begin
            failures++;
            close_out();
        end
        else
            chk(reg_rdata, x);
    endtask : rchk
    function automatic bit flex_exp(int f, int n);
        if (flex_enable_lo[f] !== 1'b1 || minl[f] > n)
            return 0;
        for (int i = 0; i < minl[f]; i++)
            if (msk[i][f] && pk[i] !== val[f][i])
                return 0;
        return 1;
    endfunction : flex_exp
    function automatic logic [9:0] mc_ix();
        logic [47:0] da;
        da = {pk[5], pk[4], pk[3], pk[2], pk[1], pk[0]};
        case (mc_offset)
            2'h0: return da[47:38];
            2'h1: return da[46:37];
            2'h2: return da[45:36];
            default: return da[43:34];
        endcase
    endfunction : mc_ix
    function automatic bit ip_exp(int n);
        bit r;
        r = (n >= 54);
        for (int j = 0; j < 16; j++)
            r &= (pk[38 + j] === ip6[0][j]);
        return r;
    endfunction : ip_exp
    task automatic run(input int n, input bit slow);
        int f0 [8];
        int m0, i0;
        f0 = fc;
        m0 = mc_cnt;
        i0 = ip_cnt;
        rx_byte_source_inst.send(pk, n, slow);
        if (rx_byte_source_inst.hung != 0)
        begin
            failures++;
            close_out();
        end
        else
        begin
            repeat (8) @(posedge ref_clk);
            foreach (f0[f])
                chk(fc[f] - f0[f], flex_exp(f, n));
            chk(mc_cnt - m0, pk[0][0] && hash[mc_ix()]);
            chk(ip_cnt - i0, ip_exp(n));
            $display("packet of %0d bytes done", n);
        end
    endtask : run
    // ========
    // sequence
    initial
    begin
        void'($urandom(37029));
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rchk(ENABLE_HI_REG, 16'h0000);
        rchk(MATCH_HI_REG, 16'h0000);
        rchk(IPV6_BASE, 16'h0000);
        wr(ENABLE_HI_REG, 16'hffff);
        rchk(ENABLE_HI_REG, 16'h00ff);
        chk(filter_enable_hi, 8'hff);
        $display("test reset and enable done");
        for (int k = 0; k < 6; k++)
        begin
            e = 8'($urandom);
            p = 8'($urandom);
            wr(ENABLE_HI_REG, {8'hff, e});
            wr(MATCH_HI_REG, 16'h0000);
            @(posedge ref_clk);
            hi_filter_pass <= p;
            @(posedge ref_clk);
            hi_filter_pass <= 8'h00;
            rchk(MATCH_HI_REG, {8'h00, p & e});
        end
        wr(ENABLE_HI_REG, 16'h0000);
        $display("test status done");
        for (int r = 0; r < 64; r++)
            wr(MTA_BASE + r, 16'h0000);
        for (int j = 0; j < 16; j++)
        begin
            ip6[0][j] = ipa[127 - 8 * j -: 8];
            ip6[1][j] = 8'($urandom);
        end
        for (int h = 0; h < 16; h++)
            wr(IPV6_BASE + h, {ip6[h / 8][2 * (h % 8) + 1], ip6[h / 8][2 * (h % 8)]});
        rchk(IPV6_BASE, 16'h80fe);
        for (int s = 0; s < 2; s++)
        begin
            @(posedge ref_clk);
            proxy_sel <= 2'(s);
            repeat (2) @(posedge ref_clk);
            for (int j = 0; j < 16; j++)
                ex[8 * j +: 8] = ip6[s][j];
            chk(proxy_addr, ex);
            foreach (pk[i])
                pk[i] = 8'($urandom);
            for (int j = 0; j < 16; j++)
                pk[38 + j] = ip6[s][j];
            run(54, s[0]);
        end
        $display("test ipv6 done");
        for (int o = 0; o < 8; o++)
        begin
            @(posedge ref_clk);
            mc_offset <= 2'(o);
            @(posedge ref_clk);
            foreach (pk[i])
                pk[i] = 8'($urandom);
            pk[0][0] = (o < 4);
            wr(hb, 16'h0000);
            hash = '{default: 0};
            ix = mc_ix();
            hash[ix] = 1'b1;
            hb = MTA_BASE + 2 * ix[9:5] + ix[4];
            wr(hb, 16'h0001 << ix[3:0]);
            wr(hb ^ 1, 16'h0000);
            run(16, o[0]);
        end
        $display("test multicast done");
        @(posedge ref_clk);
        flex_enable_lo <= 8'h00;
        for (int i = 0; i < 16; i++)
        begin
            msk[i] = (i == 0) ? 8'hff : 8'($urandom);
            wr(MASK_BASE + i, {8'($urandom), msk[i]});
            for (int q = 0; q < 8; q += 2)
            begin
                val[q][i] = 8'($urandom);
                val[q + 1][i] = 8'($urandom);
                wr(vb[q / 2] + 2 * i, {val[q + 1][i], val[q][i]});
            end
        end
        rchk(MASK_BASE + 15, {8'h00, msk[15]});
        for (int q = 0; q < 4; q++)
            rchk(vb[q] + 30, {val[2 * q + 1][15], val[2 * q][15]});
        wr(VAL45_BASE + 1, 16'hffff);
        rchk(VAL45_BASE + 1, 16'h0000);
        @(posedge ref_clk);
        foreach (minl[f])
        begin
            minl[f] = (f > 5) ? f + 8 : $urandom_range(13, 1);
            min_len[f] <= 11'(minl[f]);
        end
        flex_enable_lo <= 8'hdf;
        for (int t = 0; t < 8; t++)
        begin
            foreach (pk[i])
                pk[i] = 8'($urandom);
            for (int i = 0; i < 16; i++)
                if (msk[i][t])
                    pk[i] = val[t][i];
            run(14, t[0]);
            pk[0] = ~pk[0];
            run(14, 1'b0);
        end
        m = full_seen;
        fork
            run(14, 1'b0);
            wr(ENABLE_HI_REG, 16'h0000, 12);
        join
        chk(full_seen > m, 1'b1);
        $display("test flex done");
        close_out();
    end
endmodule : wake_packet_filter_tables_tb_top
